// ==== tlic_top.sv ====
// What this block does
// - High vectors to 0008h, low to 0018h
// - High request preempts running low routine
// - Two levels only while priority enable set
// - Bit 7 gates high sources when prioritised
// - Bit 6 gates low sources when prioritised
// - Flag, enable, global enable set: vector
// - Compatibility mode ignores priority, uses 0008h
// - Compatibility: bit 6 peripherals, bit 7 all
// - Taking a request clears its global enable
// - No low service during high routine
// - Push return address, then load vector
// - Return sets the cleared global enable again
// - Event latency three to four instruction cycles
// - Flags set regardless of any enable
// - Each source has flag, enable, priority
`timescale 1ns/1ps
`default_nettype none
module tlic_top
  import tlic_pkg::*;
#(
  parameter int unsigned NPERIPH  = 4,
  parameter int unsigned ICYC_DIV = ICYC_CLKS,
  parameter int unsigned LATENCY  = LAT_ICYC
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rstn_i,
  input  wire tlic_axi_req_t      axi_req_i,
  output var  tlic_axi_rsp_t      axi_rsp_o,
  input  wire logic               timer_overflow_i,
  input  wire logic               external_pin_irq_i,
  input  wire logic [3:0]         port_pins_i,
  input  wire logic [NPERIPH-1:0] periph_event_i,
  input  wire logic               return_from_interrupt_instr_i,
  output logic                    stack_push_o,
  output logic                    vector_load_o,
  output logic [15:0]             vector_addr_o,
  output logic                    high_active_o,
  output logic                    low_active_o,
  output logic                    irq_o
);

  if (NPERIPH < 1 || NPERIPH > 8) begin : g_bad_nperiph
    $error("NPERIPH must be 1 to 8");
  end
  if (ICYC_DIV < 1 || ICYC_DIV > 256 || LATENCY < 1 || LATENCY > 255) begin : g_bad_timing
    $error("ICYC_DIV or LATENCY out of range");
  end

  function automatic logic reg_hit(input logic [31:0] a, input logic [ADDR_W-1:0] ofs);
    reg_hit = (a[31:ADDR_W] == '0) && (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : reg_hit

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle enable

  logic [7:0] div_q;
  logic       icyc_en_q;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q     <= 8'h00;
      icyc_en_q <= 1'b0;
    end else begin
      icyc_en_q <= (div_q == 8'(ICYC_DIV - 1));
      div_q     <= (div_q == 8'(ICYC_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and AXI4-Lite state

  logic [7:0]         ctl_q, ctl_d;
  logic               prio_lvl_q;
  logic [NCORE-1:0]   cprio_q;
  logic [NPERIPH-1:0] pflag_q, pflag_d, pen_q, pprio_q;
  logic [EV_W-1:0]    evst_q, evst_d, evmask_q;
  logic               high_act_q, high_act_d, low_act_q, low_act_d;
  tlic_state_t        state_q, state_d;
  logic [7:0]         cnt_q;
  logic [15:0]        vaddr_q;
  logic               push_q, load_q, irq_q;
  logic               ext_last_q, port_seen_q;
  logic [3:0]         port_last_q;

  logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic        aw_hold_q, w_hold_q;
  logic [31:0] awaddr_q, wdata_q, rdata_q;
  logic [3:0]  wstrb_q;
  logic [1:0]  bresp_q, rresp_q;

  assign axi_rsp_o.awready = awready_q;
  assign axi_rsp_o.wready  = wready_q;
  assign axi_rsp_o.bvalid  = bvalid_q;
  assign axi_rsp_o.bresp   = bresp_q;
  assign axi_rsp_o.arready = arready_q;
  assign axi_rsp_o.rvalid  = rvalid_q;
  assign axi_rsp_o.rdata   = rdata_q;
  assign axi_rsp_o.rresp   = rresp_q;

  wire aw_take  = axi_req_i.awvalid & awready_q;
  wire w_take   = axi_req_i.wvalid & wready_q;
  wire wr_do    = aw_hold_q & w_hold_q;
  wire aw_hold_d = ~wr_do & (aw_hold_q | aw_take);
  wire w_hold_d  = ~wr_do & (w_hold_q | w_take);
  wire bvalid_d  = wr_do | (bvalid_q & ~axi_req_i.bready);
  wire ar_take  = axi_req_i.arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~axi_req_i.rready);

  wire wr_map = reg_hit(awaddr_q, OFS_INTCTL) | reg_hit(awaddr_q, OFS_RSTCTL)
              | reg_hit(awaddr_q, OFS_CPRIO) | reg_hit(awaddr_q, OFS_PFLAG)
              | reg_hit(awaddr_q, OFS_PEN) | reg_hit(awaddr_q, OFS_PPRIO)
              | reg_hit(awaddr_q, OFS_EVSTAT) | reg_hit(awaddr_q, OFS_EVMASK);
  wire wr_ok  = wr_do & wstrb_q[0];
  wire we_ctl = wr_ok & reg_hit(awaddr_q, OFS_INTCTL);
  wire we_rst = wr_ok & reg_hit(awaddr_q, OFS_RSTCTL);
  wire we_cpr = wr_ok & reg_hit(awaddr_q, OFS_CPRIO);
  wire we_pfl = wr_ok & reg_hit(awaddr_q, OFS_PFLAG);
  wire we_pen = wr_ok & reg_hit(awaddr_q, OFS_PEN);
  wire we_ppr = wr_ok & reg_hit(awaddr_q, OFS_PPRIO);
  wire we_evs = wr_ok & reg_hit(awaddr_q, OFS_EVSTAT);
  wire we_evm = wr_ok & reg_hit(awaddr_q, OFS_EVMASK);

  logic [31:0] rd_val;
  logic        rd_err;
  always_comb begin
    rd_err = 1'b0;
    rd_val = 32'h0000_0000;
    if (reg_hit(axi_req_i.araddr, OFS_INTCTL)) begin
      rd_val[7:0] = ctl_q;
    end else if (reg_hit(axi_req_i.araddr, OFS_RSTCTL)) begin
      rd_val[BIT_PRIO_LVL] = prio_lvl_q;
    end else if (reg_hit(axi_req_i.araddr, OFS_CPRIO)) begin
      rd_val[NCORE-1:0] = cprio_q;
    end else if (reg_hit(axi_req_i.araddr, OFS_PFLAG)) begin
      rd_val[NPERIPH-1:0] = pflag_q;
    end else if (reg_hit(axi_req_i.araddr, OFS_PEN)) begin
      rd_val[NPERIPH-1:0] = pen_q;
    end else if (reg_hit(axi_req_i.araddr, OFS_PPRIO)) begin
      rd_val[NPERIPH-1:0] = pprio_q;
    end else if (reg_hit(axi_req_i.araddr, OFS_STATE)) begin
      rd_val[3:0] = {low_act_q, high_act_q, state_q};
    end else if (reg_hit(axi_req_i.araddr, OFS_EVSTAT)) begin
      rd_val[EV_W-1:0] = evst_q;
    end else if (reg_hit(axi_req_i.araddr, OFS_EVMASK)) begin
      rd_val[EV_W-1:0] = evmask_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q  <= ~w_hold_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (aw_take) awaddr_q <= axi_req_i.awaddr;
      if (w_take) begin
        wdata_q <= axi_req_i.wdata;
        wstrb_q <= axi_req_i.wstrb;
      end
      if (wr_do) bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
      if (ar_take) begin
        rdata_q <= rd_val;
        rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection and request qualification

  wire priority_levels_enable = prio_lvl_q;
  wire ext_rise = external_pin_irq_i & ~ext_last_q;
  wire port_chg = port_seen_q & (port_pins_i != port_last_q);
  wire [NCORE-1:0] core_ev = {timer_overflow_i, ext_rise, port_chg};
  wire [NCORE-1:0] core_act = ctl_q[NCORE-1:0] & ctl_q[BIT_EN_LSB +: NCORE];
  wire [NPERIPH-1:0] per_act = pflag_q & pen_q;

  wire any_hi_src = |(core_act & cprio_q) | |(per_act & pprio_q);
  wire any_lo_src = |(core_act & ~cprio_q) | |(per_act & ~pprio_q);
  wire any_compat = |core_act | (ctl_q[BIT_PERIPH_EN] & |per_act);
  wire pend_high = ~high_act_q & ctl_q[BIT_GLOBAL_EN]
                 & (priority_levels_enable ? any_hi_src : any_compat);
  wire pend_low  = priority_levels_enable & ~high_act_q & ctl_q[BIT_PERIPH_EN] & any_lo_src;
  wire pend_any  = pend_high | pend_low;

  wire go_push = (state_q == ST_WAIT) & icyc_en_q & pend_any
               & (cnt_q == 8'(LATENCY - 1));
  wire ret_high = return_from_interrupt_instr_i & (high_act_q | ~low_act_q);
  wire ret_low  = return_from_interrupt_instr_i & ~high_act_q & low_act_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (icyc_en_q && pend_any) state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (!pend_any) state_d = ST_IDLE;
        else if (go_push) state_d = ST_PUSH;
      end
      ST_PUSH: state_d = ST_LOAD;
      default: state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    ctl_d = ctl_q;
    if (we_ctl) ctl_d = wdata_q[7:0];
    if (ret_high) ctl_d[BIT_GLOBAL_EN] = 1'b1;
    if (ret_low) ctl_d[BIT_PERIPH_EN] = 1'b1;
    if (go_push && pend_high) ctl_d[BIT_GLOBAL_EN] = 1'b0;
    if (go_push && !pend_high) ctl_d[BIT_PERIPH_EN] = 1'b0;
    ctl_d[NCORE-1:0] = ctl_d[NCORE-1:0] | core_ev;
    pflag_d = (we_pfl ? wdata_q[NPERIPH-1:0] : pflag_q) | periph_event_i;
    high_act_d = (high_act_q & ~ret_high) | (go_push & pend_high);
    low_act_d  = (low_act_q & ~ret_low) | (go_push & ~pend_high);
    evst_d = (evst_q & ~(we_evs ? wdata_q[EV_W-1:0] : {EV_W{1'b0}}))
           | {return_from_interrupt_instr_i, go_push};
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q     <= ST_IDLE;
      cnt_q       <= 8'h00;
      ctl_q       <= RST_INTCTL;
      prio_lvl_q  <= RST_PRIO_LVL;
      cprio_q     <= RST_CPRIO;
      pflag_q     <= '0;
      pen_q       <= '0;
      pprio_q     <= '1;
      evst_q      <= '0;
      evmask_q    <= '0;
      high_act_q  <= 1'b0;
      low_act_q   <= 1'b0;
      vaddr_q     <= VEC_HIGH;
      push_q      <= 1'b0;
      load_q      <= 1'b0;
      irq_q       <= 1'b0;
      ext_last_q  <= 1'b0;
      port_last_q <= 4'h0;
      port_seen_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= (state_q == ST_WAIT) ? cnt_q + 8'(icyc_en_q) : 8'h00;
      ctl_q       <= ctl_d;
      pflag_q     <= pflag_d;
      evst_q      <= evst_d;
      high_act_q  <= high_act_d;
      low_act_q   <= low_act_d;
      ext_last_q  <= external_pin_irq_i;
      port_last_q <= port_pins_i;
      port_seen_q <= 1'b1;
      push_q      <= go_push;
      load_q      <= (state_q == ST_PUSH);
      irq_q       <= |(evst_q & evmask_q);
      if (go_push) vaddr_q <= (pend_high ? VEC_HIGH : VEC_LOW);
      if (we_rst) prio_lvl_q <= wdata_q[BIT_PRIO_LVL];
      if (we_cpr) cprio_q <= wdata_q[NCORE-1:0];
      if (we_pen) pen_q <= wdata_q[NPERIPH-1:0];
      if (we_ppr) pprio_q <= wdata_q[NPERIPH-1:0];
      if (we_evm) evmask_q <= wdata_q[EV_W-1:0];
    end
  end

  assign stack_push_o  = push_q;
  assign vector_load_o = load_q;
  assign vector_addr_o = vaddr_q;
  assign high_active_o = high_act_q;
  assign low_active_o  = low_act_q;
  assign irq_o         = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [15:0] wait_clks_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) wait_clks_q <= 16'h0000;
    else wait_clks_q <= (state_q == ST_WAIT) ? wait_clks_q + 16'h0001 : 16'h0000;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  a_push_then_load: assert property (stack_push_o |=> vector_load_o && $stable(vector_addr_o))
    else $error("vector load did not follow stack push");
  a_vector_select: assert property (vector_load_o |->
    vector_addr_o == (high_active_o ? VEC_HIGH : VEC_LOW))
    else $error("vector address does not match level");
  a_compat_vector: assert property (go_push && !priority_levels_enable |=> ##1 vector_addr_o == VEC_HIGH)
    else $error("compatibility request used low vector");
  a_take_clears_en: assert property (go_push && pend_high |=> !ctl_q[BIT_GLOBAL_EN])
    else $error("global enable not cleared on entry");
  a_low_not_nested: assert property (high_active_o |=> !$rose(low_active_o))
    else $error("low service began inside high routine");
  a_preempt_low: assert property (low_active_o && pend_high && state_q == ST_IDLE
    && icyc_en_q |=> state_q == ST_WAIT)
    else $error("high request did not preempt low routine");
  a_latency_fixed: assert property (stack_push_o |->
    wait_clks_q == 16'(LATENCY * ICYC_DIV))
    else $error("request latency wrong");
  a_flag_sets: assert property (timer_overflow_i |=> ctl_q[BIT_TMR_FLAG])
    else $error("timer flag not set by event");
  a_flag_holds: assert property (ctl_q[BIT_EXT_FLAG] && !we_ctl |=> ctl_q[BIT_EXT_FLAG])
    else $error("flag cleared without software write");
  a_port_flag: assert property (port_chg |=> ctl_q[BIT_PORT_FLAG])
    else $error("port change flag missed");
  a_return_enable: assert property (return_from_interrupt_instr_i && high_act_q
    && !go_push |=> !high_active_o && ctl_q[BIT_GLOBAL_EN])
    else $error("return did not restore high enable");
  a_irq_level: assert property ((evst_q & evmask_q) != '0 |=> irq_o)
    else $error("interrupt output low with unmasked status");

endmodule : tlic_top
`default_nettype wire

// ==== tlic_pkg.sv ====
`default_nettype none
package tlic_pkg;

  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INTCTL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RSTCTL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CPRIO  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PFLAG  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PEN    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PPRIO  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATE  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_EVSTAT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_EVMASK = 8'h20;

  // Interrupt control register fields
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam int unsigned BIT_PERIPH_EN = 6;
  localparam int unsigned BIT_EN_LSB    = 3;
  localparam int unsigned BIT_PORT_FLAG = 0;
  localparam int unsigned BIT_EXT_FLAG  = 1;
  localparam int unsigned BIT_TMR_FLAG  = 2;
  localparam int unsigned NCORE         = 3;
  // Reset control register field
  localparam int unsigned BIT_PRIO_LVL  = 7;

  // Reset values
  localparam logic [7:0]       RST_INTCTL = 8'h00;
  localparam logic             RST_PRIO_LVL = 1'b0;
  localparam logic [NCORE-1:0] RST_CPRIO  = 3'h7;

  // Vectors
  localparam logic [15:0] VEC_HIGH = 16'h0008;
  localparam logic [15:0] VEC_LOW  = 16'h0018;

  // Timing: system clocks per instruction cycle, instruction cycles of latency
  localparam int unsigned ICYC_CLKS = 4;
  localparam int unsigned LAT_ICYC  = 3;

  // Event status bits
  localparam int unsigned EV_TAKEN  = 0;
  localparam int unsigned EV_RETURN = 1;
  localparam int unsigned EV_W      = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } tlic_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tlic_axi_rsp_t;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_PUSH, ST_LOAD} tlic_state_t;

endpackage : tlic_pkg
`default_nettype wire

// ==== tlic_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        push_i,
  input  wire logic        load_i,
  input  wire logic [15:0] vec_i,
  input  wire logic        ret_req_i,
  output logic             ret_o,
  output logic [7:0]       n_take_o,
  output logic [15:0]      pc_o,
  output logic             order_ok_o
);
  logic push_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      push_q     <= 1'b0;
      ret_o      <= 1'b0;
      n_take_o   <= 8'h00;
      pc_o       <= 16'h0000;
      order_ok_o <= 1'b1;
    end else begin
      push_q <= push_i;
      // Return pulse is the return request delayed by one cycle
      ret_o  <= ret_req_i;
      if (load_i) begin
        pc_o <= vec_i;
      end
      if (push_i) begin
        n_take_o <= n_take_o + 8'h01;
      end
      // Load must come exactly one cycle after push
      if (load_i != push_q) begin
        order_ok_o <= 1'b0;
      end
    end
  end
endmodule : tlic_core_model
`default_nettype wire

// ==== tlic_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tlic_top_tb
  import tlic_pkg::*;
;
  localparam int DIV = 1;
  localparam int LAT = LAT_ICYC;
  logic          clk;
  logic          rstn;
  tlic_axi_req_t req;
  tlic_axi_rsp_t rsp;
  logic          tmr;
  logic          ext;
  logic [3:0]    pins;
  logic [3:0]    pev;
  logic          ret;
  logic          ret_req;
  logic          push;
  logic          load;
  logic [15:0]   vec;
  logic          hact;
  logic          lact;
  logic          irq;
  logic [7:0]    n_take;
  logic [15:0]   pc;
  logic          ook;
  logic [1:0]    br;
  logic [1:0]    rr;
  logic [31:0]   rdv;
  logic [7:0]    nt;
  int            num_errors;
  int            n_tests;
  int            n;

  tlic_top #(.NPERIPH(4), .ICYC_DIV(DIV), .LATENCY(LAT)) dut_u (
    .sys_clk_i(clk), .rstn_i(rstn), .axi_req_i(req), .axi_rsp_o(rsp),
    .timer_overflow_i(tmr), .external_pin_irq_i(ext), .port_pins_i(pins),
    .periph_event_i(pev), .return_from_interrupt_instr_i(ret),
    .stack_push_o(push), .vector_load_o(load), .vector_addr_o(vec),
    .high_active_o(hact), .low_active_o(lact), .irq_o(irq));
  tlic_core_model core_u (
    .clk_i(clk), .rstn_i(rstn), .push_i(push), .load_i(load), .vec_i(vec),
    .ret_req_i(ret_req), .ret_o(ret), .n_take_o(n_take), .pc_o(pc),
    .order_ok_o(ook));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic tk(input int c);
    repeat (c) @(posedge clk);
  endtask : tk

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("Error at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= 32'(a);
    req.wvalid  <= 1'b1;
    req.wdata   <= 32'(d);
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && rsp.awready === 1'b1) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready === 1'b1) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    while (rsp.bvalid !== 1'b1) @(posedge clk);
    br = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= 32'(a);
    req.rready  <= 1'b1;
    @(posedge clk);
    while (rsp.arready !== 1'b1) @(posedge clk);
    req.arvalid <= 1'b0;
    @(posedge clk);
    while (rsp.rvalid !== 1'b1) @(posedge clk);
    rdv = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd

  task automatic wait_push();
    n = 0;
    while (push !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    tk(2);
  endtask : wait_push

  task automatic ptmr();
    @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
  endtask : ptmr

  task automatic do_ret();
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    tk(3);
  endtask : do_ret

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    num_errors++;
    close_out();
  end

  initial begin
    req = '0;
    {tmr, ext, pins, pev, ret_req, rstn} = '0;
    num_errors = 0;
    n_tests = 0;
    tk(3);
    rstn <= 1'b1;
    // Reset values and refused accesses
    rd(OFS_INTCTL);
    chk(rdv, 32'(RST_INTCTL), "ctl reset");
    rd(OFS_RSTCTL);
    chk(32'(rdv[7]), 32'(RST_PRIO_LVL), "prio reset");
    rd(OFS_CPRIO);
    chk(32'(rdv[2:0]), 32'(RST_CPRIO), "cprio reset");
    rd(8'h40);
    chk(32'(rr), 32'(RESP_SLVERR), "unmapped read");
    wr(OFS_STATE, 8'h00);
    chk(32'(br), 32'(RESP_SLVERR), "ro write");
    $display("test reset done");
    // Flags set with every enable off, and stay set
    ptmr();
    @(posedge clk);
    pins <= 4'h8;
    ext <= 1'b1;
    @(posedge clk);
    pev <= 4'h1;
    @(posedge clk);
    pev <= 4'h0;
    tk(2);
    rd(OFS_INTCTL);
    chk(rdv, 32'h07, "polled flags");
    ptmr();
    rd(OFS_INTCTL);
    chk(rdv, 32'h07, "flags hold");
    rd(OFS_PFLAG);
    chk(rdv, 32'h01, "periph flag");
    chk(32'(n_take), 32'h0, "no vector");
    wr(OFS_INTCTL, 8'h00);
    wr(OFS_PFLAG, 8'h00);
    rd(OFS_INTCTL);
    chk(rdv, 32'h00, "flags cleared");
    ext <= 1'b0;
    $display("test flags done");
    // Compatibility mode, external pin, interrupt line
    wr(OFS_CPRIO, 8'h00);
    wr(OFS_EVMASK, 8'h01);
    wr(OFS_INTCTL, 8'h90);
    @(posedge clk);
    ext <= 1'b1;
    wait_push();
    // Drive edge to flag adds one clock, push seen one edge after launch
    chk(32'(n >= LAT*DIV+3 && n <= (LAT+1)*DIV+2), 32'h1, "latency");
    chk(32'(pc), 32'(VEC_HIGH), "compat vector");
    chk(32'(ook), 32'h1, "push then load");
    chk(32'(hact), 32'h1, "high active");
    rd(OFS_INTCTL);
    chk(rdv, 32'h12, "global cleared");
    chk(32'(irq), 32'h1, "irq set");
    wr(OFS_EVMASK, 8'h00);
    tk(2);
    chk(32'(irq), 32'h0, "irq masked");
    wr(OFS_EVMASK, 8'h01);
    tk(2);
    chk(32'(irq), 32'h1, "irq unmasked");
    wr(OFS_EVSTAT, 8'h03);
    tk(2);
    chk(32'(irq), 32'h0, "irq cleared");
    wr(OFS_INTCTL, 8'h10);
    do_ret();
    chk(32'(hact), 32'h0, "left routine");
    rd(OFS_INTCTL);
    chk(rdv, 32'h90, "global restored");
    ext <= 1'b0;
    $display("test compat done");
    // Peripheral sources need bit 6 as well in compatibility mode
    wr(OFS_PEN, 8'h01);
    wr(OFS_INTCTL, 8'h80);
    @(posedge clk);
    pev <= 4'h1;
    @(posedge clk);
    pev <= 4'h0;
    nt = n_take;
    tk(10);
    chk(32'(n_take), 32'(nt), "periph gated");
    wr(OFS_INTCTL, 8'hc0);
    wait_push();
    chk(32'(n_take), 32'(nt) + 32'h1, "periph taken");
    chk(32'(pc), 32'(VEC_HIGH), "periph vector");
    wr(OFS_PFLAG, 8'h00);
    do_ret();
    wr(OFS_INTCTL, 8'h00);
    $display("test periph done");
    // Two-level mode
    wr(OFS_RSTCTL, 8'h80);
    wr(OFS_CPRIO, 8'h03);
    wr(OFS_INTCTL, 8'h70);
    ptmr();
    wait_push();
    chk(32'(pc), 32'(VEC_LOW), "low vector");
    chk(32'(lact), 32'h1, "low active");
    rd(OFS_INTCTL);
    chk(rdv, 32'h34, "low global cleared");
    @(posedge clk);
    ext <= 1'b1;
    nt = n_take;
    tk(10);
    chk(32'(n_take), 32'(nt), "high gated");
    wr(OFS_INTCTL, 8'hb2);
    wait_push();
    chk(32'(pc), 32'(VEC_HIGH), "preempt vector");
    chk(32'({hact, lact}), 32'h3, "both active");
    wr(OFS_INTCTL, 8'h70);
    nt = n_take;
    ptmr();
    tk(10);
    chk(32'(n_take), 32'(nt), "low held off");
    wr(OFS_INTCTL, 8'h30);
    do_ret();
    chk(32'({hact, lact}), 32'h1, "high left first");
    rd(OFS_INTCTL);
    chk(rdv, 32'hb0, "high global restored");
    do_ret();
    chk(32'(lact), 32'h0, "low left");
    rd(OFS_INTCTL);
    chk(rdv, 32'hf0, "low global restored");
    $display("test priority done");
    close_out();
  end
endmodule : tlic_top_tb
`default_nettype wire
